/* File: hw/scsr_cfg.svh */
// Constants for the constant store and recall command block
`ifndef SCSR_CFG_SVH
`define SCSR_CFG_SVH
`define SCSR_WORD_W 32
`define SCSR_FRAC_W 16
`define SCSR_REG_COUNT 100
`define SCSR_IDX_W 7
`define SCSR_MAX_IDX_WIDE 7'h63
`define SCSR_MAX_IDX_NARROW 7'h31
`define SCSR_RESET_WORD 32'h0000_0000
`endif

/* File: hw/scsr_pkg.sv */
// Types for the constant store and recall command block
`include "scsr_cfg.svh"
package scsr_pkg;
  typedef logic [`SCSR_WORD_W-1:0] scsr_word_type;
  typedef logic [`SCSR_IDX_W-1:0] scsr_idx_type;
  typedef enum logic [1:0] {
    SCSR_CMD_NONE,
    SCSR_CMD_RECALL,
    SCSR_CMD_STORE
  } scsr_cmd_type;
  typedef enum {
    SCSR_IDLE,
    SCSR_DONE
  } scsr_state_type;
endpackage : scsr_pkg

/* File: hw/scsr_core.sv */
// Constant store and recall command execution against the calculator stack
`timescale 1ns/1ps
`include "scsr_cfg.svh"
module scsr_core (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Build straps
  input wire logic late_build,
  input wire logic extended_memory_option,
  // Command request
  input wire logic cmd_valid,
  input wire scsr_pkg::scsr_cmd_type cmd,
  input wire scsr_pkg::scsr_word_type top_entry,
  input wire scsr_pkg::scsr_word_type second_entry,
  input wire logic second_is_wfm_addr,
  input wire scsr_pkg::scsr_word_type waveform_number,
  // Stack update answer
  output logic done,
  output logic error,
  output logic pop_top,
  output logic push_valid,
  output scsr_pkg::scsr_word_type push_value,
  output logic replace_top_valid,
  output scsr_pkg::scsr_word_type replace_top_value
);
  import scsr_pkg::*;

  scsr_word_type const_mem [`SCSR_REG_COUNT];
  scsr_state_type state;
  scsr_state_type next_state;
  logic next_done, next_error, next_pop, next_push, next_replace;
  scsr_word_type next_push_value, next_replace_value;
  logic wr_en;
  scsr_idx_type wr_idx;
  scsr_word_type wr_data;

  // Signed fixed point, round half away from zero; -0.4 rounds to 0 and stays legal
  function automatic logic [`SCSR_WORD_W-1:0] round_index(input scsr_word_type v);
    logic [`SCSR_WORD_W-1:0] mag;
    logic [`SCSR_WORD_W-1:0] r;
    mag = v[`SCSR_WORD_W-1] ? (~v + 32'h1) : v;
    r = (mag + (32'h1 << (`SCSR_FRAC_W - 1))) >> `SCSR_FRAC_W;
    round_index = (v[`SCSR_WORD_W-1] && r != 32'h0) ? 32'hffff_ffff : r;
  endfunction : round_index

  logic [`SCSR_WORD_W-1:0] rnd;
  scsr_idx_type idx;
  scsr_idx_type store_max;
  logic recall_ok, store_ok;
  assign rnd = round_index(top_entry);
  assign idx = rnd[`SCSR_IDX_W-1:0];
  assign store_max = (late_build || extended_memory_option) ? `SCSR_MAX_IDX_WIDE : `SCSR_MAX_IDX_NARROW;
  assign recall_ok = rnd <= {25'h0, `SCSR_MAX_IDX_WIDE};
  assign store_ok = rnd <= {25'h0, store_max};

  always_comb begin
    next_state = SCSR_IDLE;
    next_done = 1'b0;
    next_error = 1'b0;
    next_pop = 1'b0;
    next_push = 1'b0;
    next_replace = 1'b0;
    next_push_value = push_value;
    next_replace_value = replace_top_value;
    wr_en = 1'b0;
    wr_idx = idx;
    wr_data = second_entry;
    case (state)
      SCSR_IDLE: begin
        if (cmd_valid && cmd == SCSR_CMD_RECALL) begin
          next_state = SCSR_DONE;
          next_done = 1'b1;
          if (!recall_ok) begin
            next_error = 1'b1;
          end else begin
            next_pop = 1'b1;
            next_push = 1'b1;
            next_push_value = const_mem[idx];
          end
        end else if (cmd_valid && cmd == SCSR_CMD_STORE) begin
          next_state = SCSR_DONE;
          next_done = 1'b1;
          if (!store_ok) begin
            next_error = 1'b1;
          end else begin
            wr_en = 1'b1;
            next_pop = 1'b1;
            if (second_is_wfm_addr) begin
              next_replace = 1'b1;
              next_replace_value = waveform_number;
            end
          end
        end
      end
      // The answer cycle takes no new request, which keeps the stack owner time to settle
      SCSR_DONE: next_state = SCSR_IDLE;
      default: next_state = SCSR_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= SCSR_IDLE;
      done <= 1'b0;
      error <= 1'b0;
      pop_top <= 1'b0;
      push_valid <= 1'b0;
      push_value <= `SCSR_RESET_WORD;
      replace_top_valid <= 1'b0;
      replace_top_value <= `SCSR_RESET_WORD;
    end else begin
      state <= next_state;
      done <= next_done;
      error <= next_error;
      pop_top <= next_pop;
      push_valid <= next_push;
      push_value <= next_push_value;
      replace_top_valid <= next_replace;
      replace_top_value <= next_replace_value;
    end
  end

  // Constant registers are not reset, like battery-backed storage
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      const_mem[wr_idx] <= wr_data;
    end
  end

  a_err_no_stack: assert property (@(posedge core_clk) disable iff (rst)
    error |-> !pop_top && !push_valid && !replace_top_valid)
    else $error("error with stack change");
  a_err_with_done: assert property (@(posedge core_clk) disable iff (rst)
    error |-> done)
    else $error("error without done");
  a_reject_no_write: assert property (@(posedge core_clk) disable iff (rst)
    (state == SCSR_IDLE && cmd_valid && cmd == SCSR_CMD_STORE && !store_ok
     && rnd <= {25'h0, `SCSR_MAX_IDX_WIDE}) |=> const_mem[$past(idx)] == $past(const_mem[idx]))
    else $error("refused store changed a register");
  a_recall_popush: assert property (@(posedge core_clk) disable iff (rst)
    (state == SCSR_IDLE && cmd_valid && cmd == SCSR_CMD_RECALL && recall_ok) |=> pop_top && push_valid && done)
    else $error("recall did not pop and push");
  a_done_pulse: assert property (@(posedge core_clk) disable iff (rst)
    done |=> !done)
    else $error("done held longer than one cycle");
  // no answer without a taken request
  a_no_stray_done: assert property (@(posedge core_clk) disable iff (rst)
    !(state == SCSR_IDLE && cmd_valid && cmd != SCSR_CMD_NONE) |=> !done)
    else $error("done without a taken request");
  a_recall_value: assert property (@(posedge core_clk) disable iff (rst)
    (state == SCSR_IDLE && cmd_valid && cmd == SCSR_CMD_RECALL && recall_ok && !wr_en)
    |=> push_value == $past(const_mem[idx])) else $error("recall value wrong");
  // recall never rewrites the new top
  a_recall_no_replace: assert property (@(posedge core_clk) disable iff (rst)
    (state == SCSR_IDLE && cmd_valid && cmd == SCSR_CMD_RECALL) |=> !replace_top_valid)
    else $error("recall replaced the top entry");
  a_push_hold: assert property (@(posedge core_clk) disable iff (rst)
    !push_valid |-> push_value == $past(push_value))
    else $error("recalled value moved");
  a_store_pop: assert property (@(posedge core_clk) disable iff (rst)
    (state == SCSR_IDLE && cmd_valid && cmd == SCSR_CMD_STORE && store_ok) |=> pop_top && !push_valid)
    else $error("store did not pop");
  a_store_write: assert property (@(posedge core_clk) disable iff (rst)
    wr_en |=> const_mem[$past(wr_idx)] == $past(second_entry))
    else $error("store write lost");
  a_store_wfm: assert property (@(posedge core_clk) disable iff (rst)
    (wr_en && second_is_wfm_addr) |=> replace_top_valid && replace_top_value == $past(waveform_number))
    else $error("waveform number missing");
  // new top written only in the same cycle as a pop
  a_replace_after_pop: assert property (@(posedge core_clk) disable iff (rst)
    replace_top_valid |-> pop_top && !push_valid && !error)
    else $error("top replaced without a pop");
  a_narrow_range: assert property (@(posedge core_clk) disable iff (rst)
    (state == SCSR_IDLE && cmd_valid && cmd == SCSR_CMD_STORE && !late_build && !extended_memory_option
     && rnd > {25'h0, `SCSR_MAX_IDX_NARROW}) |=> error && done) else $error("narrow range not enforced");
  // narrow build takes up to 49
  a_narrow_accept: assert property (@(posedge core_clk) disable iff (rst)
    (state == SCSR_IDLE && cmd_valid && cmd == SCSR_CMD_STORE && !late_build
     && rnd <= {25'h0, `SCSR_MAX_IDX_NARROW}) |=> !error && pop_top)
    else $error("narrow range refused a legal index");
  // late build takes up to 99
  a_wide_range: assert property (@(posedge core_clk) disable iff (rst)
    (state == SCSR_IDLE && cmd_valid && cmd == SCSR_CMD_STORE && late_build && rnd <= {25'h0, `SCSR_MAX_IDX_WIDE})
    |=> !error ##1 !done) else $error("wide range rejected");
  a_recall_range: assert property (@(posedge core_clk) disable iff (rst)
    (state == SCSR_IDLE && cmd_valid && cmd == SCSR_CMD_RECALL && rnd > {25'h0, `SCSR_MAX_IDX_WIDE}) |=> error)
    else $error("recall range not enforced");

  // Main scenarios
  c_recall: cover property (@(posedge core_clk) disable iff (rst) push_valid);
  c_store: cover property (@(posedge core_clk) disable iff (rst) pop_top && !push_valid && !replace_top_valid);
  c_store_wfm: cover property (@(posedge core_clk) disable iff (rst) replace_top_valid);
  c_reject: cover property (@(posedge core_clk) disable iff (rst) error);
  // A request in the answer cycle is dropped without a sign
  c_busy_request: cover property (@(posedge core_clk) disable iff (rst) state == SCSR_DONE && cmd_valid);
endmodule : scsr_core

/* File: testbench/scsr_src.sv */
// Command source model driving calculator commands and stack entries
`timescale 1ns/1ps
module scsr_src (
  // Clock
  input wire logic core_clk,
  // Command request
  output logic cmd_valid,
  output scsr_pkg::scsr_cmd_type cmd,
  output scsr_pkg::scsr_word_type top_entry,
  output scsr_pkg::scsr_word_type second_entry,
  output logic second_is_wfm_addr,
  output scsr_pkg::scsr_word_type waveform_number
);
  import scsr_pkg::*;
  initial begin
    cmd_valid = 1'b0;
    cmd = SCSR_CMD_NONE;
    top_entry = 32'h0;
    second_entry = 32'h0;
    second_is_wfm_addr = 1'b0;
    waveform_number = 32'h0;
  end
  task send(input scsr_cmd_type c, input int idx, input int frac, input logic w, input scsr_word_type y,
            input scsr_word_type n, input int hold = 1);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd <= c;
    top_entry <= scsr_word_type'(idx * 65536 + frac);
    second_entry <= y;
    second_is_wfm_addr <= w;
    waveform_number <= n;
    repeat (hold) @(posedge core_clk);
    // Released entries go stale, so show the inverse rather than the old value
    cmd_valid <= 1'b0;
    cmd <= SCSR_CMD_NONE;
    top_entry <= ~top_entry;
    second_entry <= ~second_entry;
    second_is_wfm_addr <= ~second_is_wfm_addr;
    waveform_number <= ~waveform_number;
  endtask : send
endmodule : scsr_src

/* File: testbench/stack_constant_store_recall_test.sv */
// Self-checking bench for the constant store and recall block
`timescale 1ns/1ps
module stack_constant_store_recall_test;
  import scsr_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic late_build = 1'b1;
  logic extended_memory_option = 1'b0;
  logic cmd_valid, second_is_wfm_addr, done, error, pop_top, push_valid, replace_top_valid;
  scsr_cmd_type cmd;
  scsr_word_type top_entry, second_entry, waveform_number, push_value, replace_top_value;
  int failures = 0;
  int checked = 0;
  int seed = 32'h2a2e2be8;
  scsr_word_type model [0:99];
  always #10 core_clk = ~core_clk;
  scsr_src src (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd(cmd), .top_entry(top_entry),
    .second_entry(second_entry), .second_is_wfm_addr(second_is_wfm_addr), .waveform_number(waveform_number));
  scsr_core dut (.core_clk(core_clk), .rst(rst), .late_build(late_build),
    .extended_memory_option(extended_memory_option), .cmd_valid(cmd_valid), .cmd(cmd), .top_entry(top_entry),
    .second_entry(second_entry), .second_is_wfm_addr(second_is_wfm_addr), .waveform_number(waveform_number),
    .done(done), .error(error), .pop_top(pop_top), .push_valid(push_valid), .push_value(push_value),
    .replace_top_valid(replace_top_valid), .replace_top_value(replace_top_value));
  task chk(input scsr_word_type seen, input scsr_word_type exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task give_verdict;
    if (failures == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // One command, answer checked in the cycle after it is taken
  task op(input scsr_cmd_type c, input int idx, input int frac, input logic ok);
    logic w;
    scsr_word_type y, n;
    w = 1'($random(seed));
    y = $random(seed);
    n = $random(seed);
    src.send(c, idx, frac, w, y, n);
    #1;
    chk(scsr_word_type'(done), 32'h1);
    chk(scsr_word_type'(error), scsr_word_type'(!ok));
    chk(scsr_word_type'(pop_top), scsr_word_type'(ok));
    if (c == SCSR_CMD_RECALL) begin
      chk(scsr_word_type'(push_valid), scsr_word_type'(ok));
      chk(scsr_word_type'(replace_top_valid), 32'h0);
      if (ok) chk(push_value, model[idx]);
    end else begin
      chk(scsr_word_type'(push_valid), 32'h0);
      chk(scsr_word_type'(replace_top_valid), scsr_word_type'(ok && w));
      if (ok && w) chk(replace_top_value, n);
      if (ok) model[idx] = y;
    end
    // Every answer is a single-cycle pulse
    @(posedge core_clk);
    #1;
    chk(scsr_word_type'({done, error, pop_top, push_valid, replace_top_valid}), 32'h0);
  endtask : op
  // Request held into the answer cycle, or an empty command, must get no answer there
  task no_answer(input scsr_cmd_type c, input int hold);
    fork
      src.send(c, 3, 0, 1'b1, 32'h0, 32'h0, hold);
      begin
        repeat (2) @(posedge core_clk);
        #1;
        chk(scsr_word_type'(done), scsr_word_type'(c != SCSR_CMD_NONE));
        if (c != SCSR_CMD_NONE) chk(push_value, model[3]);
        repeat (hold - 1) @(posedge core_clk);
        #1;
        chk(scsr_word_type'({done, pop_top, push_valid}), 32'h0);
      end
    join
  endtask : no_answer
  initial begin
    #100000;
    failures++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 100; i++) op(SCSR_CMD_STORE, i, $random(seed) % 32767, 1'b1);
    // Exact half rounds away from zero
    op(SCSR_CMD_STORE, 7, -32768, 1'b1);
    op(SCSR_CMD_STORE, 0, -32768, 1'b0);
    for (int i = 99; i >= 0; i--) op(SCSR_CMD_RECALL, i, $random(seed) % 32767, 1'b1);
    // Busy-cycle request and empty command get no answer
    no_answer(SCSR_CMD_RECALL, 2);
    no_answer(SCSR_CMD_NONE, 1);
    op(SCSR_CMD_STORE, 100, 0, 1'b0);
    op(SCSR_CMD_RECALL, 100, 0, 1'b0);
    @(posedge core_clk);
    late_build <= 1'b0;
    op(SCSR_CMD_STORE, 50, 0, 1'b0);
    op(SCSR_CMD_STORE, 49, 0, 1'b1);
    op(SCSR_CMD_RECALL, 50, 0, 1'b1);
    op(SCSR_CMD_RECALL, 99, 0, 1'b1);
    @(posedge core_clk);
    extended_memory_option <= 1'b1;
    op(SCSR_CMD_STORE, 99, 0, 1'b1);
    op(SCSR_CMD_RECALL, 99, 0, 1'b1);
    op(SCSR_CMD_STORE, 100, 0, 1'b0);
    give_verdict();
  end
endmodule : stack_constant_store_recall_test
